// *** hw/pwm_timer_pkg.sv ***
// shared constants, register map and carrier types of the timer-based pwm channel
package pwm_timer_pkg;

	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_TIMER_A_COUNT = 10'h106;
	localparam logic [IDX_W-1:0] IDX_TIMER_B_UPPER_HOLD = 10'h108;
	localparam logic [IDX_W-1:0] IDX_TIMER_B_COUNT = 10'h10a;
	localparam logic [IDX_W-1:0] IDX_TIMER_A_PERIOD = 10'h10c;
	localparam logic [IDX_W-1:0] IDX_TIMER_B_PERIOD = 10'h10e;
	localparam logic [IDX_W-1:0] IDX_TIMER_A_CONTROL = 10'h110;
	localparam logic [IDX_W-1:0] IDX_TIMER_B_CONTROL = 10'h112;
	localparam logic [IDX_W-1:0] IDX_DUTY_SECONDARY = 10'h120;
	localparam logic [IDX_W-1:0] IDX_DUTY_ACTIVE = 10'h122;
	localparam logic [IDX_W-1:0] IDX_PWM_CONTROL = 10'h124;
	localparam logic [IDX_W-1:0] IDX_INT_STATUS = 10'h126;
	localparam logic [IDX_W-1:0] IDX_INT_MASK = 10'h128;

	// timer control fields
	localparam int CTRL_RUN_BIT = 15;
	localparam int CTRL_PRESCALE_LO = 4;
	localparam int CTRL_PAIR_WIDE_BIT = 3;
	localparam logic [15:0] CTRL_A_IMPL_MASK = 16'ha07a;
	localparam logic [15:0] CTRL_B_IMPL_MASK = 16'ha072;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	localparam logic [15:0] DUTY_RESET = 16'h0000;
	localparam logic [15:0] DUTY_OFF = 16'h0000;

	// pwm control and interrupt fields
	localparam int PWM_EN_BIT = 0;
	localparam int PWM_BASE_B_BIT = 1;
	localparam int INT_A_BIT = 0;
	localparam int INT_B_BIT = 1;
	localparam logic [1:0] FLAGS_RESET = 2'h0;

	// one count increment per instruction cycle of four oscillator periods
	localparam int OSC_PER_INSTR = 4;
	localparam int PRESC_W = 10;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_type;

	typedef struct packed {
		logic wr_en;
		logic [IDX_W-1:0] wr_idx;
		logic [15:0] wr_data;
		logic [1:0] wr_strb;
		logic rd_en;
		logic [IDX_W-1:0] rd_idx;
	} regbus_type;

	typedef struct packed {
		logic [PRESC_W-1:0] cnt;
	} prescaler_state_type;

	function automatic logic [PRESC_W-1:0] prescale_terminal(input logic [1:0] sel);
		int factor;
		unique case (sel)
			2'h0: factor = 1;
			2'h1: factor = 8;
			2'h2: factor = 64;
			default: factor = 256;
		endcase
		return PRESC_W'(OSC_PER_INSTR * factor - 1);
	endfunction : prescale_terminal

	function automatic logic reg_hit(input logic [IDX_W-1:0] idx);
		return idx inside {IDX_TIMER_A_COUNT, IDX_TIMER_B_UPPER_HOLD, IDX_TIMER_B_COUNT,
			IDX_TIMER_A_PERIOD, IDX_TIMER_B_PERIOD, IDX_TIMER_A_CONTROL, IDX_TIMER_B_CONTROL,
			IDX_DUTY_SECONDARY, IDX_DUTY_ACTIVE, IDX_PWM_CONTROL, IDX_INT_STATUS, IDX_INT_MASK};
	endfunction : reg_hit

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
		input logic [1:0] strb);
		return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
	endfunction : merge16

endpackage : pwm_timer_pkg

// *** hw/pwm_prescaler.sv ***
// instruction-cycle divider and timer prescaler giving one count-enable pulse
`timescale 1ns/1ns
module pwm_prescaler (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [1:0] prescale_sel,
	output logic tick
);
	import pwm_timer_pkg::*;

	prescaler_state_type st_r;
	prescaler_state_type st_nxt;
	logic [PRESC_W-1:0] terminal;

	assign terminal = prescale_terminal(prescale_sel);
	// >= so that a smaller prescale chosen mid-count does not wrap the full range
	assign tick = run && (st_r.cnt >= terminal);

	always_comb begin
		st_nxt = st_r;
		if (!run || tick) begin
			st_nxt.cnt = '0;
		end else begin
			st_nxt.cnt = PRESC_W'(st_r.cnt + 1'b1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r.cnt <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	AST_PRESCALE_ONE: assert property (@(posedge core_clk) disable iff (rst)
		tick && prescale_sel == 2'h0 ##1 (run && prescale_sel == 2'h0) [*4]
		|-> !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3) && tick)
		else $error("count enable not every four cycles at prescale one");

endmodule : pwm_prescaler

// *** hw/pwm_axi_slave.sv ***
// axi4-lite slave turning bus transfers into register strobes
`timescale 1ns/1ns
module pwm_axi_slave (
	input wire logic core_clk,
	input wire logic rst,
	input pwm_timer_pkg::axi_req_type axi_req,
	output pwm_timer_pkg::axi_rsp_type axi_rsp,
	output pwm_timer_pkg::regbus_type regbus,
	input wire logic [15:0] rd_data
);
	import pwm_timer_pkg::*;

	typedef struct packed {
		logic aw_held;
		logic w_held;
		logic [IDX_W-1:0] wr_idx;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
	} slave_state_type;

	slave_state_type st_r;
	slave_state_type st_nxt;
	logic aw_take;
	logic w_take;
	logic ar_take;

	assign aw_take = axi_req.awvalid && !st_r.aw_held && !st_r.bvalid;
	assign w_take = axi_req.wvalid && !st_r.w_held && !st_r.bvalid;
	assign ar_take = axi_req.arvalid && !st_r.rvalid;

	always_comb begin
		axi_rsp.awready = !st_r.aw_held && !st_r.bvalid;
		axi_rsp.wready = !st_r.w_held && !st_r.bvalid;
		axi_rsp.bvalid = st_r.bvalid;
		axi_rsp.bresp = st_r.bresp;
		axi_rsp.arready = !st_r.rvalid;
		axi_rsp.rvalid = st_r.rvalid;
		axi_rsp.rdata = 32'(st_r.rdata);
		axi_rsp.rresp = st_r.rresp;
		regbus.wr_en = st_r.aw_held && st_r.w_held;
		regbus.wr_idx = st_r.wr_idx;
		regbus.wr_data = st_r.wdata;
		regbus.wr_strb = st_r.wstrb;
		regbus.rd_en = ar_take;
		regbus.rd_idx = axi_req.araddr[ADDR_W-1:2];
	end

	always_comb begin
		st_nxt = st_r;
		if (aw_take) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.wr_idx = axi_req.awaddr[ADDR_W-1:2];
		end
		if (w_take) begin
			st_nxt.w_held = 1'b1;
			st_nxt.wdata = axi_req.wdata[15:0];
			st_nxt.wstrb = axi_req.wstrb[1:0];
		end
		if (st_r.aw_held && st_r.w_held) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = reg_hit(st_r.wr_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (st_r.bvalid && axi_req.bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (ar_take) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_data;
			st_nxt.rresp = reg_hit(regbus.rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (st_r.rvalid && axi_req.rready) begin
			st_nxt.rvalid = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule : pwm_axi_slave

// *** hw/timer_pwm_channel.sv ***
// two 16-bit timers, pairable to 32 bits, timing one pwm output with interrupt flags
// Notes on behaviour
// - pwm period is (period + 1) times four oscillator periods times the prescale factor
// - count equal to period clears on the next increment, starting a new period
// - each period start sets the pin high, but zero duty keeps it low
// - duty above the period value keeps the pin high with no low interval
// - secondary duty is copied into active duty only at period starts
// - each period start sets the interrupt flag of the time-base timer, the timer b flag when paired
// - upper-half latch serves timer b only when timers are paired to 32 bits
// - after reset counts and latch are untouched, periods all ones, controls zero
// - unimplemented bits of the timer registers read as zero
`timescale 1ns/1ns
module timer_pwm_channel (
	input wire logic core_clk,
	input wire logic rst,
	input pwm_timer_pkg::axi_req_type axi_req,
	output pwm_timer_pkg::axi_rsp_type axi_rsp,
	output logic compare_output_pin,
	output logic timer_irq
);
	import pwm_timer_pkg::*;

	typedef struct packed {
		logic [15:0] cnt_a;
		logic [15:0] cnt_b;
		logic [15:0] upper_half_latch;
		logic [15:0] pr_a;
		logic [15:0] pr_b;
		logic [15:0] ctrl_a;
		logic [15:0] ctrl_b;
		logic [15:0] duty_secondary;
		logic [15:0] duty_active;
		logic [1:0] pwm_ctl;
		logic [1:0] int_status;
		logic [1:0] int_mask;
		logic pin;
	} channel_state_type;

	channel_state_type st_r;
	channel_state_type st_nxt;
	regbus_type regbus;
	logic [15:0] rd_data;
	logic pair_wide_select;
	logic run_a;
	logic run_b;
	logic tick_a;
	logic tick_b;
	logic evt_a;
	logic evt_b;
	logic evt_pair;
	logic base_b;
	logic base_evt;
	logic base_tick;
	logic [15:0] base_cnt_next;
	logic [15:0] base_period;
	logic [15:0] cnt_a_next;
	logic [15:0] cnt_b_next;
	logic [31:0] pair_next;

	assign pair_wide_select = st_r.ctrl_a[CTRL_PAIR_WIDE_BIT];
	assign run_a = st_r.ctrl_a[CTRL_RUN_BIT];
	// in paired mode timer b is clocked by timer a's prescaler only
	assign run_b = st_r.ctrl_b[CTRL_RUN_BIT] && !pair_wide_select;

	pwm_prescaler presc_a (
		.core_clk(core_clk),
		.rst(rst),
		.run(run_a),
		.prescale_sel(st_r.ctrl_a[CTRL_PRESCALE_LO +: 2]),
		.tick(tick_a)
	);

	pwm_prescaler presc_b (
		.core_clk(core_clk),
		.rst(rst),
		.run(run_b),
		.prescale_sel(st_r.ctrl_b[CTRL_PRESCALE_LO +: 2]),
		.tick(tick_b)
	);

	pwm_axi_slave bus (
		.core_clk(core_clk),
		.rst(rst),
		.axi_req(axi_req),
		.axi_rsp(axi_rsp),
		.regbus(regbus),
		.rd_data(rd_data)
	);

	assign evt_a = tick_a && !pair_wide_select && (st_r.cnt_a == st_r.pr_a);
	assign evt_pair = tick_a && pair_wide_select && ({st_r.cnt_b, st_r.cnt_a} == {st_r.pr_b, st_r.pr_a});
	assign evt_b = (tick_b && (st_r.cnt_b == st_r.pr_b)) || evt_pair;

	always_comb begin
		cnt_a_next = st_r.cnt_a;
		cnt_b_next = st_r.cnt_b;
		pair_next = evt_pair ? 32'h0000_0000 : 32'({st_r.cnt_b, st_r.cnt_a} + 32'h0000_0001);
		if (pair_wide_select) begin
			if (tick_a) begin
				cnt_b_next = pair_next[31:16];
				cnt_a_next = pair_next[15:0];
			end
		end else begin
			if (tick_a) begin
				cnt_a_next = evt_a ? 16'h0000 : 16'(st_r.cnt_a + 16'h0001);
			end
			if (tick_b) begin
				cnt_b_next = evt_b ? 16'h0000 : 16'(st_r.cnt_b + 16'h0001);
			end
		end
	end

	// paired mode compares duty with the low word of the 32-bit count
	assign base_b = st_r.pwm_ctl[PWM_BASE_B_BIT] && !pair_wide_select;
	assign base_evt = pair_wide_select ? evt_pair : (base_b ? evt_b : evt_a);
	assign base_tick = base_b ? tick_b : tick_a;
	assign base_cnt_next = base_b ? cnt_b_next : cnt_a_next;
	assign base_period = base_b ? st_r.pr_b : st_r.pr_a;

	always_comb begin
		unique case (regbus.rd_idx)
			IDX_TIMER_A_COUNT: rd_data = st_r.cnt_a;
			IDX_TIMER_B_UPPER_HOLD: rd_data = st_r.upper_half_latch;
			IDX_TIMER_B_COUNT: rd_data = st_r.cnt_b;
			IDX_TIMER_A_PERIOD: rd_data = st_r.pr_a;
			IDX_TIMER_B_PERIOD: rd_data = st_r.pr_b;
			IDX_TIMER_A_CONTROL: rd_data = st_r.ctrl_a & CTRL_A_IMPL_MASK;
			IDX_TIMER_B_CONTROL: rd_data = st_r.ctrl_b & CTRL_B_IMPL_MASK;
			IDX_DUTY_SECONDARY: rd_data = st_r.duty_secondary;
			IDX_DUTY_ACTIVE: rd_data = st_r.duty_active;
			IDX_PWM_CONTROL: rd_data = 16'(st_r.pwm_ctl);
			IDX_INT_STATUS: rd_data = 16'(st_r.int_status);
			IDX_INT_MASK: rd_data = 16'(st_r.int_mask);
			default: rd_data = 16'h0000;
		endcase
	end

	always_comb begin
		logic [1:0] flag_set;
		logic [1:0] flag_clr;
		flag_set = 2'h0;
		flag_clr = 2'h0;
		st_nxt = st_r;
		st_nxt.cnt_a = cnt_a_next;
		st_nxt.cnt_b = cnt_b_next;

		// pwm pin follows the selected time base
		if (!st_r.pwm_ctl[PWM_EN_BIT]) begin
			st_nxt.pin = 1'b0;
		end else if (base_evt) begin
			st_nxt.duty_active = st_r.duty_secondary;
			st_nxt.pin = (st_r.duty_secondary != DUTY_OFF);
		end else if (base_tick && base_cnt_next == st_r.duty_active) begin
			// a duty above the period is never reached, so the pin stays high
			st_nxt.pin = 1'b0;
		end

		flag_set[INT_A_BIT] = evt_a;
		flag_set[INT_B_BIT] = evt_b;

		// reading the low count in paired mode freezes the upper half for a later read
		if (regbus.rd_en && regbus.rd_idx == IDX_TIMER_A_COUNT && pair_wide_select) begin
			st_nxt.upper_half_latch = st_r.cnt_b;
		end

		if (regbus.wr_en) begin
			unique case (regbus.wr_idx)
				IDX_TIMER_A_COUNT: begin
					st_nxt.cnt_a = merge16(st_r.cnt_a, regbus.wr_data, regbus.wr_strb);
					if (pair_wide_select) begin
						st_nxt.cnt_b = st_r.upper_half_latch;
					end
				end
				IDX_TIMER_B_UPPER_HOLD: begin
					st_nxt.upper_half_latch = merge16(st_r.upper_half_latch, regbus.wr_data, regbus.wr_strb);
				end
				IDX_TIMER_B_COUNT: begin
					st_nxt.cnt_b = merge16(st_r.cnt_b, regbus.wr_data, regbus.wr_strb);
				end
				IDX_TIMER_A_PERIOD: begin
					st_nxt.pr_a = merge16(st_r.pr_a, regbus.wr_data, regbus.wr_strb);
				end
				IDX_TIMER_B_PERIOD: begin
					st_nxt.pr_b = merge16(st_r.pr_b, regbus.wr_data, regbus.wr_strb);
				end
				IDX_TIMER_A_CONTROL: begin
					st_nxt.ctrl_a = merge16(st_r.ctrl_a, regbus.wr_data, regbus.wr_strb) & CTRL_A_IMPL_MASK;
				end
				IDX_TIMER_B_CONTROL: begin
					st_nxt.ctrl_b = merge16(st_r.ctrl_b, regbus.wr_data, regbus.wr_strb) & CTRL_B_IMPL_MASK;
				end
				IDX_DUTY_SECONDARY: begin
					st_nxt.duty_secondary = merge16(st_r.duty_secondary, regbus.wr_data, regbus.wr_strb);
				end
				IDX_PWM_CONTROL: begin
					if (regbus.wr_strb[0]) begin
						st_nxt.pwm_ctl = regbus.wr_data[1:0];
					end
				end
				IDX_INT_STATUS: begin
					if (regbus.wr_strb[0]) begin
						flag_clr = regbus.wr_data[1:0];
					end
				end
				IDX_INT_MASK: begin
					if (regbus.wr_strb[0]) begin
						st_nxt.int_mask = regbus.wr_data[1:0];
					end
				end
				default: begin
				end
			endcase
		end
		// a flag raised in the same cycle as its clear survives
		st_nxt.int_status = (st_r.int_status & ~flag_clr) | flag_set;
	end

	// counts and the upper-half latch keep whatever they held through reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r.pr_a <= PERIOD_RESET;
			st_r.pr_b <= PERIOD_RESET;
			st_r.ctrl_a <= CTRL_RESET;
			st_r.ctrl_b <= CTRL_RESET;
			st_r.duty_secondary <= DUTY_RESET;
			st_r.duty_active <= DUTY_RESET;
			st_r.pwm_ctl <= FLAGS_RESET;
			st_r.int_status <= FLAGS_RESET;
			st_r.int_mask <= FLAGS_RESET;
			st_r.pin <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign compare_output_pin = st_r.pin;
	assign timer_irq = |(st_r.int_status & st_r.int_mask);

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	AST_PERIOD_CLEAR: assert property (evt_a && !(regbus.wr_en && regbus.wr_idx == IDX_TIMER_A_COUNT)
		|=> st_r.cnt_a == 16'h0000)
		else $error("timer a count not cleared after period match");

	AST_PIN_SET: assert property (st_r.pwm_ctl[PWM_EN_BIT] && base_evt && st_r.duty_secondary != DUTY_OFF
		|=> compare_output_pin)
		else $error("pin not set at period start");

	AST_ZERO_DUTY: assert property (base_evt && st_r.duty_secondary == DUTY_OFF |=> !compare_output_pin)
		else $error("pin high at period start with zero duty");

	AST_HIGH_OVER: assert property (compare_output_pin && st_r.pwm_ctl[PWM_EN_BIT] && !base_evt
		&& st_r.duty_active > base_period && $stable(st_r.pwm_ctl) |=> compare_output_pin)
		else $error("pin fell although duty exceeds period");

	AST_DUTY_LATCH: assert property (st_r.pwm_ctl[PWM_EN_BIT] && base_evt
		|=> st_r.duty_active == $past(st_r.duty_secondary))
		else $error("active duty not loaded at period start");

	AST_FLAG_SET: assert property (evt_a |=> st_r.int_status[INT_A_BIT] ##0 timer_irq == st_r.int_mask[INT_A_BIT]
		|| st_r.int_status[INT_B_BIT])
		else $error("timer a flag missing after period match");

	AST_HOLD_LATCH: assert property (regbus.rd_en && regbus.rd_idx == IDX_TIMER_A_COUNT && pair_wide_select
		&& !regbus.wr_en |=> st_r.upper_half_latch == $past(st_r.cnt_b))
		else $error("upper half not latched on paired low read");

	AST_RESET_VALUES: assert property (@(posedge core_clk) $past(rst) |-> st_r.pr_a == PERIOD_RESET
		&& st_r.pr_b == PERIOD_RESET && st_r.ctrl_a == CTRL_RESET && st_r.ctrl_b == CTRL_RESET)
		else $error("period or control not at reset value");

	AST_UNIMPL_ZERO: assert property (regbus.rd_en && regbus.rd_idx == IDX_TIMER_B_CONTROL
		|=> axi_rsp.rvalid && (axi_rsp.rdata[15:0] & ~CTRL_B_IMPL_MASK) == 16'h0000)
		else $error("unimplemented control bit read non-zero");

	AST_DUTY_MATCH: assert property (st_r.pwm_ctl[PWM_EN_BIT] && base_tick && !base_evt
		&& base_cnt_next == st_r.duty_active |=> !compare_output_pin ##1 !compare_output_pin || base_evt)
		else $error("pin not cleared at duty match");

	COV_PERIOD_EVENT: cover property (st_r.pwm_ctl[PWM_EN_BIT] && base_evt);
	COV_PIN_CYCLE: cover property ($rose(compare_output_pin) ##[1:200] $fell(compare_output_pin));
	COV_IRQ: cover property ($rose(timer_irq));
	COV_PAIRED: cover property (evt_pair);

endmodule : timer_pwm_channel

// *** verification/tb.sv ***
// self-checking testbench of the timer-based pwm channel, driven over axi4-lite
`timescale 1ns/1ns
module tb;
	import pwm_timer_pkg::*;

	logic core_clk = 1'b0;
	logic rst = 1'b1;
	axi_req_type req = '0;
	axi_rsp_type rsp;
	logic compare_output_pin;
	logic timer_irq;
	int mismatches = 0;
	int checks_done = 0;
	int fac[4] = '{1, 8, 64, 256};

	timer_pwm_channel dut_u (
		.core_clk(core_clk),
		.rst(rst),
		.axi_req(req),
		.axi_rsp(rsp),
		.compare_output_pin(compare_output_pin),
		.timer_irq(timer_irq)
	);

	always #5 core_clk = ~core_clk;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk_val

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s response %h expected %h", $time, msg, got, exp);
		end
	endtask : chk_resp

	// the master waits on the slave handshake with no assumed latency, only a loop bound
	task automatic axi_write(input logic [IDX_W-1:0] idx, input logic [15:0] d, output logic [1:0] resp);
		int n;
		@(posedge core_clk);
		req.awvalid <= 1'b1;
		req.awaddr <= {idx, 2'b00};
		req.wvalid <= 1'b1;
		req.wdata <= {16'h0000, d};
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid && n < 50);
		resp = rsp.bresp;
		req.bready <= 1'b0;
		if (n >= 50) chk_resp(2'h3, 2'h0, "write handshake timeout");
	endtask : axi_write

	task automatic axi_read(input logic [IDX_W-1:0] idx, output logic [15:0] d, output logic [1:0] resp);
		int n;
		@(posedge core_clk);
		req.arvalid <= 1'b1;
		req.araddr <= {idx, 2'b00};
		req.rready <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid && n < 50);
		d = rsp.rdata[15:0];
		resp = rsp.rresp;
		req.rready <= 1'b0;
		if (n >= 50) chk_resp(2'h3, 2'h0, "read handshake timeout");
	endtask : axi_read

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
		logic [1:0] r;
		axi_write(idx, d, r);
		chk_resp(r, RESP_OKAY, "write");
	endtask : wr

	task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [15:0] exp, input string msg);
		logic [15:0] d;
		logic [1:0] r;
		axi_read(idx, d, r);
		chk_resp(r, RESP_OKAY, msg);
		chk_val(d, exp, msg);
	endtask : rd_chk

	task automatic wait_pin(input logic v, output int n);
		n = 0;
		while (compare_output_pin !== v && n <= 4000) begin
			@(negedge core_clk);
			n++;
		end
		if (n > 4000) chk_val(16'h0001, 16'h0000, "pin wait timeout");
	endtask : wait_pin

	task automatic pin_times(output int hi, output int lo);
		int n;
		wait_pin(1'b0, n);
		wait_pin(1'b1, n);
		wait_pin(1'b0, hi);
		wait_pin(1'b1, lo);
	endtask : pin_times

	task automatic start_pwm(input logic [15:0] per, input logic [15:0] duty, input int sel);
		wr(IDX_TIMER_A_CONTROL, CTRL_RESET);
		wr(IDX_TIMER_A_COUNT, 16'h0000);
		wr(IDX_TIMER_A_PERIOD, per);
		wr(IDX_DUTY_SECONDARY, duty);
		wr(IDX_PWM_CONTROL, 16'h0001);
		wr(IDX_TIMER_A_CONTROL, 16'h8000 | 16'(sel << CTRL_PRESCALE_LO));
	endtask : start_pwm

	task automatic test_reset_values();
		logic [15:0] d;
		logic [1:0] r;
		rd_chk(IDX_TIMER_A_PERIOD, PERIOD_RESET, "period a reset");
		rd_chk(IDX_TIMER_B_PERIOD, PERIOD_RESET, "period b reset");
		rd_chk(IDX_TIMER_A_CONTROL, 16'h0000, "control a reset");
		rd_chk(IDX_TIMER_B_CONTROL, 16'h0000, "control b reset");
		axi_read(10'h200, d, r);
		chk_resp(r, RESP_SLVERR, "unmapped read");
		axi_write(10'h200, 16'h1234, r);
		chk_resp(r, RESP_SLVERR, "unmapped write");
	endtask : test_reset_values

	task automatic test_unimpl_bits();
		wr(IDX_TIMER_A_CONTROL, 16'hffff);
		rd_chk(IDX_TIMER_A_CONTROL, 16'ha07a, "control a unused bits");
		wr(IDX_TIMER_A_CONTROL, 16'h0000);
		wr(IDX_TIMER_B_CONTROL, 16'hffff);
		rd_chk(IDX_TIMER_B_CONTROL, 16'ha072, "control b unused bits");
		wr(IDX_TIMER_B_CONTROL, 16'h0000);
	endtask : test_unimpl_bits

	task automatic test_duty_latch();
		wr(IDX_DUTY_SECONDARY, 16'h0003);
		wr(IDX_DUTY_ACTIVE, 16'h0007);
		rd_chk(IDX_DUTY_ACTIVE, 16'h0000, "active duty before boundary");
		start_pwm(16'h0004, 16'h0003, 0);
		repeat (45) @(negedge core_clk);
		wr(IDX_TIMER_A_CONTROL, CTRL_RESET);
		rd_chk(IDX_DUTY_ACTIVE, 16'h0003, "active duty after boundary");
	endtask : test_duty_latch

	// every prescale factor: full period and high time from the pin itself
	task automatic test_period_duty();
		int n;
		int hi;
		int lo;
		int p;
		int du;
		for (int s = 0; s < 4; s++) begin
			p = (s == 0) ? 4 : 1;
			du = (s == 0) ? 2 : 1;
			start_pwm(16'(p), 16'(du), s);
			@(negedge core_clk);
			wait_pin(1'b0, n);
			wait_pin(1'b1, n);
			wait_pin(1'b0, hi);
			wait_pin(1'b1, lo);
			chk_val(16'(hi + lo), 16'((p + 1) * OSC_PER_INSTR * fac[s]), "pwm period");
			chk_val(16'(hi), 16'(du * OSC_PER_INSTR * fac[s]), "pwm high time");
		end
	endtask : test_period_duty

	task automatic test_duty_edges();
		int highs;
		for (int k = 0; k < 2; k++) begin
			start_pwm(16'h0003, (k == 0) ? DUTY_OFF : 16'h0009, 0);
			repeat (20) @(negedge core_clk);
			highs = 0;
			repeat (40) begin
				@(negedge core_clk);
				if (compare_output_pin === 1'b1) highs++;
			end
			chk_val(16'(highs), (k == 0) ? 16'h0000 : 16'h0028, "pin level over two periods");
		end
	endtask : test_duty_edges

	task automatic test_irq();
		wr(IDX_TIMER_A_CONTROL, CTRL_RESET);
		rd_chk(IDX_INT_STATUS, 16'h0001, "period flag set");
		chk_val({15'h0000, timer_irq}, 16'h0000, "irq masked");
		wr(IDX_INT_MASK, 16'h0001);
		@(negedge core_clk);
		chk_val({15'h0000, timer_irq}, 16'h0001, "irq unmasked");
		wr(IDX_INT_MASK, 16'h0000);
		@(negedge core_clk);
		chk_val({15'h0000, timer_irq}, 16'h0000, "irq masked again");
		wr(IDX_INT_STATUS, 16'h0001);
		rd_chk(IDX_INT_STATUS, 16'h0000, "flag cleared");
	endtask : test_irq

	task automatic test_pair();
		wr(IDX_PWM_CONTROL, 16'h0000);
		wr(IDX_TIMER_A_CONTROL, 16'h0008);
		wr(IDX_TIMER_B_UPPER_HOLD, 16'h1234);
		wr(IDX_TIMER_A_COUNT, 16'h0005);
		rd_chk(IDX_TIMER_B_COUNT, 16'h1234, "upper half loaded from latch");
		wr(IDX_TIMER_B_COUNT, 16'h00ab);
		rd_chk(IDX_TIMER_A_COUNT, 16'h0005, "lower half");
		rd_chk(IDX_TIMER_B_UPPER_HOLD, 16'h00ab, "latch caught upper half");
		wr(IDX_TIMER_A_CONTROL, CTRL_RESET);
	endtask : test_pair

	// timer b as time base, then the paired 32-bit count timing the pin and raising the b flag
	task automatic test_base_b_and_pair();
		int hi;
		int lo;
		wr(IDX_INT_STATUS, 16'h0003);
		wr(IDX_TIMER_B_COUNT, 16'h0000);
		wr(IDX_TIMER_B_PERIOD, 16'h0001);
		wr(IDX_DUTY_SECONDARY, 16'h0001);
		wr(IDX_PWM_CONTROL, 16'h0003);
		wr(IDX_TIMER_B_CONTROL, 16'h8000);
		pin_times(hi, lo);
		chk_val(16'(hi + lo), 16'(2 * OSC_PER_INSTR), "timer b pwm period");
		chk_val(16'(hi), 16'(OSC_PER_INSTR), "timer b pwm high time");
		wr(IDX_TIMER_B_CONTROL, CTRL_RESET);
		rd_chk(IDX_INT_STATUS, 16'h0002, "timer b period flag");
		wr(IDX_INT_STATUS, 16'h0002);
		wr(IDX_TIMER_A_CONTROL, 16'h0008);
		wr(IDX_TIMER_A_PERIOD, 16'h0001);
		wr(IDX_TIMER_B_PERIOD, 16'h0000);
		wr(IDX_TIMER_B_UPPER_HOLD, 16'h0000);
		wr(IDX_TIMER_A_COUNT, 16'h0000);
		wr(IDX_PWM_CONTROL, 16'h0001);
		wr(IDX_TIMER_A_CONTROL, 16'h8008);
		pin_times(hi, lo);
		chk_val(16'(hi + lo), 16'(2 * OSC_PER_INSTR), "paired pwm period");
		chk_val(16'(hi), 16'(OSC_PER_INSTR), "paired pwm high time");
		wr(IDX_TIMER_A_CONTROL, CTRL_RESET);
		rd_chk(IDX_INT_STATUS, 16'h0002, "paired period flag");
		wr(IDX_PWM_CONTROL, 16'h0000);
	endtask : test_base_b_and_pair

	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		test_reset_values();
		test_unimpl_bits();
		test_duty_latch();
		test_period_duty();
		test_duty_edges();
		test_irq();
		test_pair();
		test_base_b_and_pair();
		give_verdict();
	end

	// whole run needs about 6000 cycles; allow a wide margin
	initial begin
		repeat (60000) @(posedge core_clk);
		mismatches++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end

endmodule : tb
